// *** hw/msr_master_status.sv ***
// master status and reset register with ready and host lock-out
// What this block does
// R1 - master reset clears; soft resets leave it
// R2 - ready pin mirrors status bit 15
// R3 - ready low during init, self-test, resets
// R4 - host access locked out while not ready
// R5 - not ready: reads return this register, except one that meets a pending core read reply
// R6 - bit 13 holds strap caught at reset release
// R7 - bit 12 starts monitor reset until done
// R8 - bit 11: clear terminal two start, reset
// R9 - bit 10: clear terminal one start, reset
// R10 - terminal request set keeps ready low
// R11 - completion self-clears bit, ready returns high
// R12 - bit 9 shows controller message in progress
// R13 - bit 9 falls only after updates written
// R14 - bit 14 unused, reads zero
// R15 - read-only bits ignore writes; zero no effect
`timescale 1ns/1ps
module msr_master_status
  import msr_pkg::*;
#(
  parameter int AW       = MSR_AW,
  parameter int DW       = MSR_DW,
  parameter int INIT_CYC = MSR_INIT_CYC,
  parameter int SRST_CYC = MSR_SRST_CYC
) (
  input  wire logic          clock,
  input  wire logic          rst_n,
  input  wire logic          auto_init_strap,
  input  wire logic          self_test_busy,
  input  wire logic          controller_msg_active,
  input  wire logic          controller_updates_done,
  input  wire logic          host_wr,
  input  wire logic          host_rd,
  input  wire logic [AW-1:0] host_addr,
  input  wire logic [DW-1:0] host_wdata,
  input  wire logic [DW-1:0] core_rdata,
  output logic               ready,
  output logic [DW-1:0]      host_rdata,
  output logic               host_rvalid,
  output logic               core_wr,
  output logic               core_rd,
  output logic [AW-1:0]      core_addr,
  output logic [DW-1:0]      core_wdata,
  output logic               rt1_clear_start_exec,
  output logic               rt2_clear_start_exec,
  output logic [MSR_NREQ-1:0] soft_reset_pulse
);
  // rst_n is the master reset pin (master_reset_pin_n)
  logic rs1_q, rs2_q;
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rs1_q <= 1'b0;
      rs2_q <= 1'b0;
    end else begin
      rs1_q <= 1'b1;
      rs2_q <= rs1_q;
    end
  end
  wire logic rst_l_n = rs2_q;

  // caught by a clocked process after release, never by the async reset
  logic strap_q, strap_d, strap_done_q, strap_done_d;
  logic [MSR_CW+4:0] init_q, init_d;
  logic mon_q, mon_d, rt2_q, rt2_d, rt1_q, rt1_d;
  logic mip_q, mip_d;
  logic ready_q, ready_d;
  logic [DW-1:0] rdata_q, rdata_d;
  logic rvalid_q, rvalid_d;
  logic cwr_q, cwr_d, crd_q, crd_d;
  logic [AW-1:0] caddr_q, caddr_d;
  logic [DW-1:0] cwdata_q, cwdata_d;
  logic c1_q, c1_d, c2_q, c2_d;
  logic [MSR_NREQ-1:0] spulse_q, spulse_d;
  logic [MSR_NREQ-1:0] seq_busy, seq_pre, seq_done;
  logic [DW-1:0] status_word;
  logic          reg_hit, wr_hit;

  function automatic logic [DW-1:0] msr_pack(
    input logic rdy, input logic st, input logic m,
    input logic r2, input logic r1, input logic bc);
    logic [DW-1:0] w;
    w = '0;
    w[MSR_READY_BIT] = rdy;
    w[MSR_UNUSED_BIT] = 1'b0; // R14
    w[MSR_STRAP_BIT] = st;
    w[MSR_MON_BIT] = m;
    w[MSR_RT2_BIT] = r2;
    w[MSR_RT1_BIT] = r1;
    w[MSR_CONTROLLER_MSG_IN_PROGRESS_BIT] = bc;
    return w;
  endfunction : msr_pack

  logic [MSR_NREQ-1:0] seq_start;
  logic [MSR_NREQ-1:0] req_bits;
  assign req_bits  = {mon_q, rt2_q, rt1_q};
  assign seq_start = req_bits & ~seq_busy & ~seq_done;

  // index 2 monitor, 1 terminal two, 0 terminal one
  for (genvar i = 0; i < MSR_NREQ; i++) begin : g_seq
    logic busy_l, done_l;
    msr_sreset_seq #(.CYCLES(SRST_CYC)) u_seq (
      .clock     (clock),
      .rst_l_n   (rst_l_n),
      .start     (seq_start[i]),
      .busy      (busy_l),
      .pre_step  (seq_pre[i]),
      .act_pulse (done_l)
    );
    assign seq_busy[i] = busy_l;
    assign seq_done[i] = done_l;
  end

  assign status_word = msr_pack(ready_q, strap_q, mon_q, rt2_q, rt1_q,
                                mip_q);
  assign reg_hit = (host_addr == AW'(MSR_OFFSET));
  assign wr_hit  = host_wr && ready_q && reg_hit;

  always_comb begin
    strap_d      = strap_q;
    strap_done_d = 1'b1;
    init_d       = init_q;
    mon_d        = mon_q;
    rt2_d        = rt2_q;
    rt1_d        = rt1_q;
    mip_d        = mip_q;
    if (!strap_done_q) begin
      strap_d = auto_init_strap; // R6
      init_d  = auto_init_strap ? (MSR_CW+5)'(INIT_CYC) : '0;
    end else if (init_q != '0) begin
      init_d = init_q - 1'b1;
    end
    // only ones take effect; reads of bit 15,14,13,9 ignore writes
    if (wr_hit) begin
      mon_d = mon_q | host_wdata[MSR_MON_BIT]; // R7 R15
      rt2_d = rt2_q | host_wdata[MSR_RT2_BIT]; // R8 R15
      rt1_d = rt1_q | host_wdata[MSR_RT1_BIT]; // R9 R15
    end
    if (seq_done[2]) mon_d = 1'b0; // R11
    if (seq_done[1]) rt2_d = 1'b0; // R11
    if (seq_done[0]) rt1_d = 1'b0; // R11
    // falls only once buffer updates are done, set wins
    if (controller_msg_active) begin
      mip_d = 1'b1; // R12
    end else if (controller_updates_done) begin
      mip_d = 1'b0; // R13
    end
    ready_d = strap_done_q && (init_d == '0) && !self_test_busy
              && !mon_d && !rt2_d && !rt1_d; // R2 R3 R10 R11
  end

  always_comb begin
    rdata_d  = rdata_q;
    rvalid_d = 1'b0;
    cwr_d    = 1'b0;
    crd_d    = 1'b0;
    caddr_d  = caddr_q;
    cwdata_d = cwdata_q;
    c1_d     = seq_pre[0]; // R9
    c2_d     = seq_pre[1]; // R8
    spulse_d = seq_done;
    if (host_rd) begin
      rvalid_d = 1'b1;
      if (!ready_q || reg_hit) begin
        rdata_d = status_word; // R5
      end
    end
    if (ready_q && !reg_hit) begin
      cwr_d    = host_wr; // R4
      crd_d    = host_rd; // R4
      caddr_d  = host_addr;
      cwdata_d = host_wdata;
    end
    // core reads arrive a cycle later; pass through when not ours
    if (crd_q) begin
      rdata_d = core_rdata;
    end
  end

  always_ff @(posedge clock or negedge rst_l_n) begin
    if (!rst_l_n) begin
      strap_q      <= 1'b0; // R1
      strap_done_q <= 1'b0;
      init_q       <= '0;
      mon_q        <= 1'b0;
      rt2_q        <= 1'b0;
      rt1_q        <= 1'b0;
      mip_q        <= 1'b0;
      ready_q      <= 1'b0;
      rdata_q      <= MSR_RESET_VAL;
      rvalid_q     <= 1'b0;
      cwr_q        <= 1'b0;
      crd_q        <= 1'b0;
      caddr_q      <= '0;
      cwdata_q     <= '0;
      c1_q         <= 1'b0;
      c2_q         <= 1'b0;
      spulse_q     <= '0;
    end else begin
      strap_q      <= strap_d;
      strap_done_q <= strap_done_d;
      init_q       <= init_d;
      mon_q        <= mon_d;
      rt2_q        <= rt2_d;
      rt1_q        <= rt1_d;
      mip_q        <= mip_d;
      ready_q      <= ready_d;
      rdata_q      <= rdata_d;
      rvalid_q     <= rvalid_d;
      cwr_q        <= cwr_d;
      crd_q        <= crd_d;
      caddr_q      <= caddr_d;
      cwdata_q     <= cwdata_d;
      c1_q         <= c1_d;
      c2_q         <= c2_d;
      spulse_q     <= spulse_d;
    end
  end

  assign ready                = ready_q;
  assign host_rdata           = rdata_q;
  assign host_rvalid          = rvalid_q;
  assign core_wr              = cwr_q;
  assign core_rd              = crd_q;
  assign core_addr            = caddr_q;
  assign core_wdata           = cwdata_q;
  assign rt1_clear_start_exec = c1_q;
  assign rt2_clear_start_exec = c2_q;
  assign soft_reset_pulse     = spulse_q;

  sequence req_written_s;
    wr_hit && (host_wdata[MSR_MON_BIT] || host_wdata[MSR_RT2_BIT]
               || host_wdata[MSR_RT1_BIT]);
  endsequence
  sequence ready_held_low_s;
    !ready_q [*2];
  endsequence
  // answer built from the status word, not from the core port
  sequence status_read_s;
    host_rvalid && $past(!ready_q || reg_hit) && !$past(crd_q);
  endsequence
  sequence soft_done_s;
    seq_done != '0;
  endsequence
  sequence quiet_after_s;
    strap_done_q && init_q == '0 && !self_test_busy
    && (req_bits & ~seq_done) == '0;
  endsequence

  ready_mirror_a: assert property (@(posedge clock) disable iff (!rst_l_n)
    status_read_s |-> host_rdata[MSR_READY_BIT] == $past(ready)) // R2
    else $error("ready differs from bit 15");
  req_low_a: assert property (@(posedge clock) disable iff (!rst_l_n)
    req_written_s |=> ready_held_low_s) // R3
    else $error("ready not low after reset request");
  lockout_a: assert property (@(posedge clock) disable iff (!rst_l_n)
    !ready_q |=> !cwr_q && !crd_q) // R4
    else $error("core access while not ready");
  notready_read_a: assert property (@(posedge clock) disable iff (!rst_l_n)
    host_rd && !ready_q && !crd_q |=> host_rdata == $past(status_word)) // R5
    else $error("read while not ready not status");
  strap_hold_a: assert property (@(posedge clock) disable iff (!rst_l_n)
    strap_done_q && $past(strap_done_q) |-> $stable(strap_q)) // R6
    else $error("strap bit changed after capture");
  mon_done_a: assert property (@(posedge clock) disable iff (!rst_l_n)
    $rose(mon_q) |-> ##[1:40] !mon_q) // R7 R11
    else $error("monitor reset never completed");
  rt_clear_a: assert property (@(posedge clock) disable iff (!rst_l_n)
    $rose(rt2_q) |-> ##[1:3] c2_d) // R8
    else $error("terminal two start not cleared");
  rt1_clear_a: assert property (@(posedge clock) disable iff (!rst_l_n)
    $rose(rt1_q) |-> ##[1:3] c1_d) // R9
    else $error("terminal one start not cleared");
  rt_busy_a: assert property (@(posedge clock) disable iff (!rst_l_n)
    rt1_q || rt2_q |-> !ready_q) // R10
    else $error("ready high while terminal reset set");
  mip_set_a: assert property (@(posedge clock) disable iff (!rst_l_n)
    controller_msg_active |=> status_word[MSR_CONTROLLER_MSG_IN_PROGRESS_BIT]) // R12
    else $error("message flag not set");
  mip_fall_a: assert property (@(posedge clock) disable iff (!rst_l_n)
    $fell(mip_q) |-> $past(controller_updates_done)) // R13
    else $error("message flag fell before updates");
  unused_zero_a: assert property (@(posedge clock) disable iff (!rst_l_n)
    status_read_s |-> !host_rdata[MSR_UNUSED_BIT]) // R14
    else $error("bit 14 read as one");
  zero_write_a: assert property (@(posedge clock) disable iff (!rst_l_n)
    wr_hit && !host_wdata[MSR_MON_BIT] && !mon_q |=> !mon_q) // R15
    else $error("zero write started reset");
  strap_catch_a: assert property (@(posedge clock) disable iff (!rst_l_n)
    !strap_done_q |=> strap_q == $past(auto_init_strap)) // R6
    else $error("strap level not captured");
  init_low_a: assert property (@(posedge clock) disable iff (!rst_l_n)
    init_q != '0 |-> !ready_q) // R3
    else $error("ready high during auto-init");
  selftest_low_a: assert property (@(posedge clock) disable iff (!rst_l_n)
    self_test_busy |=> !ready_q) // R3
    else $error("ready high during self-test");
  mon_busy_a: assert property (@(posedge clock) disable iff (!rst_l_n)
    mon_q |-> !ready_q) // R7
    else $error("ready high during monitor reset");
  locked_write_a: assert property (@(posedge clock) disable iff (!rst_l_n)
    host_wr && !ready_q && seq_done == '0 |=> $stable(req_bits)) // R4
    else $error("write accepted while not ready");
  soft_done_a: assert property (@(posedge clock) disable iff (!rst_l_n)
    soft_done_s |=> (req_bits & $past(seq_done)) == '0
                    && soft_reset_pulse == $past(seq_done)) // R11
    else $error("request bit not cleared at completion");
  ready_back_a: assert property (@(posedge clock) disable iff (!rst_l_n)
    soft_done_s ##0 quiet_after_s |=> ready_q) // R11
    else $error("ready not restored after soft reset");
  rt1_pulse_a: assert property (@(posedge clock) disable iff (!rst_l_n)
    $rose(rt1_q) |-> ##2 rt1_clear_start_exec) // R9
    else $error("terminal one clear pulse late");
  rt2_pulse_a: assert property (@(posedge clock) disable iff (!rst_l_n)
    $rose(rt2_q) |-> ##2 rt2_clear_start_exec) // R8
    else $error("terminal two clear pulse late");
endmodule : msr_master_status

// *** hw/msr_pkg.sv ***
// package of constants for the master status and reset register block
package msr_pkg;
  localparam int          MSR_AW          = 16;
  localparam int          MSR_DW          = 16;
  localparam logic [15:0] MSR_OFFSET      = 16'h0001;
  localparam logic [15:0] MSR_RESET_VAL   = 16'h0000;
  localparam int          MSR_READY_BIT   = 15;
  localparam int          MSR_UNUSED_BIT  = 14;
  localparam int          MSR_STRAP_BIT   = 13;
  localparam int          MSR_MON_BIT     = 12;
  localparam int          MSR_RT2_BIT     = 11;
  localparam int          MSR_RT1_BIT     = 10;
  localparam int          MSR_CONTROLLER_MSG_IN_PROGRESS_BIT   = 9;
  localparam int          MSR_NREQ        = 3;
  localparam int          MSR_INIT_NS     = 1000;
  localparam int          MSR_CLK_NS      = 10;
  localparam int          MSR_INIT_CYC    = (MSR_INIT_NS + MSR_CLK_NS - 1)
                                            / MSR_CLK_NS;
  localparam int          MSR_SRST_CYC    = 16;
  localparam int          MSR_CW          = 8;
endpackage : msr_pkg

// *** hw/msr_sreset_seq.sv ***
// one soft reset sequencer: one-cycle pre-step on every start, then timed reset actions
`timescale 1ns/1ps
module msr_sreset_seq
  import msr_pkg::*;
#(
  parameter int CYCLES = MSR_SRST_CYC
) (
  input  wire logic clock,
  input  wire logic rst_l_n,
  input  wire logic start,
  output logic      busy,
  output logic      pre_step,
  output logic      act_pulse
);
  typedef enum logic [1:0] {
    MSR_S_IDLE = 2'b00,
    MSR_S_PRE  = 2'b01,
    MSR_S_ACT  = 2'b11
  } msr_seq_e;

  msr_seq_e          st_q, st_d;
  logic [MSR_CW-1:0] cnt_q, cnt_d;

  always_comb begin
    st_d  = st_q;
    cnt_d = cnt_q;
    case (st_q)
      MSR_S_IDLE: begin
        if (start) begin
          st_d = MSR_S_PRE;
        end
      end
      MSR_S_PRE: begin
        st_d  = MSR_S_ACT;
        cnt_d = MSR_CW'(CYCLES - 1);
      end
      MSR_S_ACT: begin
        if (cnt_q == '0) begin
          st_d = MSR_S_IDLE;
        end else begin
          cnt_d = cnt_q - 1'b1;
        end
      end
      default: st_d = MSR_S_IDLE;
    endcase
  end

  always_ff @(posedge clock or negedge rst_l_n) begin
    if (!rst_l_n) begin
      st_q  <= MSR_S_IDLE;
      cnt_q <= '0;
    end else begin
      st_q  <= st_d;
      cnt_q <= cnt_d;
    end
  end

  assign busy      = (st_q != MSR_S_IDLE);
  assign pre_step  = (st_q == MSR_S_PRE);
  assign act_pulse = (st_q == MSR_S_ACT) && (cnt_q == '0);
endmodule : msr_sreset_seq

// *** testbench/master_status_reset_reg_tb_top.sv ***
// self-checking bench for the master status and reset register
`timescale 1ns/1ps
module master_status_reset_reg_tb_top
  import msr_pkg::*;
();
  logic        clock = 1'h0, rst_n = 1'h0, auto_init_strap = 1'h1;
  logic        self_test_busy = 1'h0, controller_msg_active = 1'h0;
  logic        controller_updates_done = 1'h0, host_wr, host_rd, ready;
  logic        host_rvalid, core_wr, core_rd;
  logic        rt1_clear_start_exec, rt2_clear_start_exec, v, ok;
  logic [15:0] host_addr, host_wdata, core_rdata, host_rdata, core_addr;
  logic [15:0] core_wdata, wa, wd, d, a, n, wr_seen = 16'h0000;
  logic [15:0] seed = 16'h3C20;
  logic [2:0]  soft_reset_pulse, srp_seen;
  logic [1:0]  clr_seen;
  logic        seen_clr = 1'h0;
  int          fail_count = 0, checks_done = 0, cyc = 0;

  always #5 clock = ~clock;

  function automatic logic [15:0] fwd(logic [15:0] x);
    return x ^ 16'hC3A5;
  endfunction : fwd
  function automatic logic [15:0] stat(logic r, s, logic [2:0] q, logic b);
    return {r, 1'h0, s, q, b, 9'h000};
  endfunction : stat
  function automatic logic [15:0] xs();
    seed ^= seed << 7;
    seed ^= seed >> 9;
    seed ^= seed << 8;
    return seed;
  endfunction : xs

  // core answers only while strobed; otherwise an inverted pattern
  assign core_rdata = core_rd ? fwd(core_addr) : ~fwd(core_addr);

  msr_master_status #(.INIT_CYC(8), .SRST_CYC(4)) msr_master_status_i (
    .clock, .rst_n, .auto_init_strap, .self_test_busy,
    .controller_msg_active, .controller_updates_done, .host_wr, .host_rd,
    .host_addr, .host_wdata, .core_rdata, .ready, .host_rdata,
    .host_rvalid, .core_wr, .core_rd, .core_addr, .core_wdata,
    .rt1_clear_start_exec, .rt2_clear_start_exec, .soft_reset_pulse);

  msr_host_model msr_host_model_i (.clock, .ready, .host_rdata,
    .host_rvalid, .host_wr, .host_rd, .host_addr, .host_wdata);

  task automatic check(input logic [15:0] s, e);
    checks_done++;
    if (s !== e) begin
      fail_count++;
      $display("MISMATCH %0t seen %h expected %h", $time, s, e);
    end
  endtask : check
  task automatic wrap_up();
    if (fail_count == 0 && checks_done > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : wrap_up
  // a hang still reaches the report, counted as a mismatch
  task automatic watch_ceiling();
    wait (cyc == 3000);
    fail_count++;
    wrap_up();
  endtask : watch_ceiling
  task automatic pulse_bc(input logic m, u);
    controller_msg_active = m;
    controller_updates_done = u;
    @(posedge clock);
    #1 controller_msg_active = 1'h0;
    controller_updates_done = 1'h0;
  endtask : pulse_bc

  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (core_wr) begin
      wr_seen <= wr_seen + 16'h0001;
      wa <= core_addr;
      wd <= core_wdata;
    end
    clr_seen <= seen_clr ? 2'h0
              : clr_seen | {rt2_clear_start_exec, rt1_clear_start_exec};
    srp_seen <= seen_clr ? 3'h0 : srp_seen | soft_reset_pulse;
  end

  initial begin
    fork
      watch_ceiling();
    join_none
    repeat (4) @(posedge clock);
    #1 rst_n = 1'h1;
    repeat (5) @(posedge clock);
    #1 check(ready, 1'h0);
    msr_host_model_i.wait_ready(ok);
    msr_host_model_i.rd_word(MSR_OFFSET, d, v);
    check(d, stat(1'h1, 1'h1, 3'h0, 1'h0));
    check(d[15], ready);
    pulse_bc(1'h1, 1'h0);
    for (int i = 0; i < 3; i++) begin
      seen_clr = 1'h1;
      msr_host_model_i.access(1'h1, MSR_OFFSET, 16'h0400 << i);
      seen_clr = 1'h0;
      @(posedge clock);
      #1 check(ready, 1'h0);
      msr_host_model_i.rd_word(xs(), d, v);
      check(d, stat(1'h0, 1'h1, 3'h1 << i, 1'h1));
      check(v, 1'h1);
      msr_host_model_i.wait_ready(ok);
      check(ok, 1'h1);
      // completion pulse lands with ready; let it be caught first
      @(posedge clock);
      #1 check(srp_seen, 3'h1 << i);
      check(clr_seen, (2'h1 << i) & 2'h3);
      msr_host_model_i.rd_word(MSR_OFFSET, d, v);
      check(d, stat(1'h1, 1'h1, 3'h0, 1'h1));
    end
    // read-only bits 15, 13, 9 written both ways, bit 14 written one twice, request bits left at zero
    for (int i = 0; i < 2; i++) begin
      msr_host_model_i.access(1'h1, MSR_OFFSET, i ? 16'h41FF : 16'hE200);
      @(posedge clock);
      #1 msr_host_model_i.rd_word(MSR_OFFSET, d, v);
      check(d, stat(1'h1, 1'h1, 3'h0, 1'h1));
    end
    pulse_bc(1'h1, 1'h1);
    msr_host_model_i.rd_word(MSR_OFFSET, d, v);
    check(d[9], 1'h1);
    pulse_bc(1'h0, 1'h1);
    msr_host_model_i.rd_word(MSR_OFFSET, d, v);
    check(d, stat(1'h1, 1'h1, 3'h0, 1'h0));
    for (int i = 0; i < 6; i++) begin
      a = (i == 0) ? 16'hFFFF : xs();
      if (a == MSR_OFFSET)
        a = 16'h0002;
      n = xs();
      msr_host_model_i.access(1'h1, a, n);
      repeat (2) @(posedge clock);
      #1 check(wa, a);
      check(wd, n);
      msr_host_model_i.rd_word(a, d, v);
      check(d, fwd(a));
    end
    self_test_busy = 1'h1;
    repeat (2) @(posedge clock);
    #1 check(ready, 1'h0);
    n = wr_seen;
    msr_host_model_i.access(1'h1, 16'h0005, xs());
    repeat (2) @(posedge clock);
    #1 check(wr_seen, n);
    msr_host_model_i.rd_word(16'h0005, d, v);
    check(d, stat(1'h0, 1'h1, 3'h0, 1'h0));
    self_test_busy = 1'h0;
    msr_host_model_i.wait_ready(ok);
    check(ok, 1'h1);
    // second master reset, strap low this time, flag set beforehand
    pulse_bc(1'h1, 1'h0);
    auto_init_strap = 1'h0;
    rst_n = 1'h0;
    #1 check(ready, 1'h0);
    repeat (4) @(posedge clock);
    #1 rst_n = 1'h1;
    msr_host_model_i.wait_ready(ok);
    msr_host_model_i.rd_word(MSR_OFFSET, d, v);
    check(d, stat(1'h1, 1'h0, 3'h0, 1'h0));
    check(d[14], 1'h0);
    wrap_up();
  end
endmodule : master_status_reset_reg_tb_top

// *** testbench/msr_host_model.sv ***
// host processor model on the register port
`timescale 1ns/1ps
module msr_host_model (
  input  wire logic        clock,
  input  wire logic        ready,
  input  wire logic [15:0] host_rdata,
  input  wire logic        host_rvalid,
  output logic             host_wr,
  output logic             host_rd,
  output logic [15:0]      host_addr,
  output logic [15:0]      host_wdata
);
  initial begin
    host_wr = 1'h0;
    host_rd = 1'h0;
    host_addr = 16'h0000;
    host_wdata = 16'h0000;
  end
  // one-cycle strobe; released bus shows the inverse, never stale data
  task automatic access(input logic w, input logic [15:0] a, d);
    host_wr = w;
    host_rd = !w;
    host_addr = a;
    host_wdata = d;
    @(posedge clock);
    #1;
    host_wr = 1'h0;
    host_rd = 1'h0;
    host_addr = ~a;
    host_wdata = ~d;
  endtask : access
  // data taken two edges on, which covers forwarded reads too
  task automatic rd_word(input logic [15:0] a, output logic [15:0] d,
                         output logic v);
    access(1'h0, a, 16'h0000);
    v = host_rvalid;
    @(posedge clock);
    #1 d = host_rdata;
  endtask : rd_word
  // nothing is trusted until ready is back
  task automatic wait_ready(output logic ok);
    for (int i = 0; i < 400 && ready !== 1'h1; i++) begin
      @(posedge clock);
      #1;
    end
    ok = (ready === 1'h1);
  endtask : wait_ready
endmodule : msr_host_model
